// ---- design/tpg_generator.v ----
// Test pattern generator: control agent, command queue and streaming source
// How it works
// - Status word shows constant signature, channel count, symbols per beat, packet flag.
// - Output beats are produced only while control bit zero is one.
// - Nine-bit throttle against a pseudorandom byte sets output rate; 0 stops, 256 full.
// - Clear bit holds all counters and queue in reset until software writes zero.
// - Busy reads one while a segment is sending or commands are queued.
// - Fill field reports how many commands the queue holds.
// - Only a write to the low command word pushes a command; high goes first.
// - Segments other than a packet's last are padded to whole beats.
// - Segment channel comes from the fourteen-bit command field, low bits used.
// - First-segment flag marks packet start; ignored without packet support.
// - Last-segment flag marks packet end; ignored without packet support.
// - Error output is driven from the sixteen-bit command error field.
// - Generated symbols are XORed with the command's eight-bit corruption mask.
// - Start-hiding bit keeps the start marker low on a packet's first segment.
// - End-hiding bit keeps the end marker low on a packet's last segment.
// - Command agent has low word at offset zero and high word at one.
// - Stream output with optional framing; position kept per channel for interleaving.
// - Error width is a parameter from 0 to 31; zero drives the port low.
`default_nettype none
`include "tpg_map.vh"

module tpg_generator #(
  parameter        CHANNELS      = 4,
  parameter        CH_W          = 2,
  parameter        SYMBOL_BITS   = 8,
  parameter        SYMBOLS       = 4,
  parameter        EMPTY_W       = 2,
  parameter        PACKETS       = 1,
  parameter        ERROR_WIDTH   = 8,
  parameter        QUEUE_AW      = 4,
  parameter [15:0] SIGNATURE     = 16'h5A3C, // Arbitrary value
  parameter [15:0] THROTTLE_SEED = 16'hACE1
) (
  input  wire                           i_clock,
  input  wire                           i_rst_n,
  input  wire [1:0]                     i_csr_address,
  input  wire                           i_csr_write,
  input  wire                           i_csr_read,
  input  wire [31:0]                    i_csr_writedata,
  output reg  [31:0]                    o_csr_readdata,
  input  wire                           i_cmd_address,
  input  wire                           i_cmd_write,
  input  wire                           i_cmd_read,
  input  wire [31:0]                    i_cmd_writedata,
  output reg  [31:0]                    o_cmd_readdata,
  output reg                            o_valid,
  input  wire                           i_ready,
  output reg  [SYMBOLS*SYMBOL_BITS-1:0] o_data,
  output reg  [CH_W-1:0]                o_channel,
  output reg                            o_startofpacket,
  output reg                            o_endofpacket,
  output reg  [EMPTY_W-1:0]             o_empty,
  output reg  [((ERROR_WIDTH == 0) ? 1 : ERROR_WIDTH)-1:0] o_error
);

  // Port width of the error signal; a zero width keeps one bit tied low
  localparam ERR_PW   = (ERROR_WIDTH == 0) ? 1 : ERROR_WIDTH;
  localparam NENT     = 1 << CH_W;
  localparam DEPTH    = 1 << QUEUE_AW;
  localparam DATA_W   = SYMBOLS * SYMBOL_BITS;
  localparam ST_IDLE  = 1'b0;
  localparam ST_SEND  = 1'b1;
  localparam [15:0] SPB16   = SYMBOLS;
  localparam [7:0]  CHAN8   = CHANNELS;
  localparam [6:0]  SYM7    = SYMBOLS;
  localparam        PKT_ON  = (PACKETS != 0);

  // Reset release through two flip-flops
  reg rst_meta;
  reg rst_sync;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  wire rst_n = rst_sync;

  reg                ctl_enable;
  reg [8:0]          ctl_throttle;
  reg                ctl_clear;
  reg [31:0]         cmd_low;
  reg [31:0]         cmd_high;
  reg [63:0]         q_mem [0:DEPTH-1];
  reg [QUEUE_AW-1:0] wr_ptr;
  reg [QUEUE_AW-1:0] rd_ptr;
  reg [QUEUE_AW:0]   q_count;
  reg                state;
  reg [15:0]         seg_left;
  reg [CH_W-1:0]     seg_chan;
  reg                seg_first_flag;
  reg                seg_last_flag;
  reg                seg_first_beat;
  reg [15:0]         seg_err;
  reg [7:0]          seg_mask;
  reg                seg_hide_start;
  reg                seg_hide_end;
  reg [15:0]         lfsr;

  wire [DEPTH*0+NENT*16-1:0] pos_flat;
  wire [15:0]        pos_cur = pos_flat[seg_chan*16 +: 16];

  // Queue state
  wire q_full  = (q_count == DEPTH);
  wire q_empty = (q_count == 0);
  wire push    = i_cmd_write && (i_cmd_address == `TPG_CMD_LOW) &&
                 !q_full && !ctl_clear;
  wire pop     = (state == ST_IDLE) && !q_empty && !ctl_clear;

  // Throttle: pass when the random byte falls below the limit
  wire thr_pass = ({1'b0, lfsr[7:0]} < ctl_throttle);

  // Beat launch when enabled, throttled in and the sink can take it
  wire beat_go  = (state == ST_SEND) && ctl_enable && !ctl_clear && thr_pass &&
                  (!o_valid || i_ready);
  wire last_beat = (seg_left <= SPB16);
  wire pkt_end   = last_beat && seg_last_flag;

  // Symbols that count toward the position: padding fills the beat
  wire [15:0] n_sym = pkt_end ? seg_left : SPB16;
  wire [15:0] empty_wide = pkt_end ? (SPB16 - seg_left) : 16'h0000;

  wire [15:0] fill_wide = {{(15-QUEUE_AW){1'b0}}, q_count};
  wire [8:0]  fill_val  = fill_wide[8:0];
  wire        busy      = (state == ST_SEND) || !q_empty || o_valid;

  wire [63:0] head      = q_mem[rd_ptr];
  wire [13:0] head_chan = head[`TPG_LO_CHAN_MSB:`TPG_LO_CHAN_LSB];
  wire [31:0] chan_wide = {18'h00000, head_chan};
  wire [ERR_PW+15:0] err_ext = {{ERR_PW{1'b0}}, seg_err};
  wire [SYMBOL_BITS+7:0] mask_ext = {{SYMBOL_BITS{1'b0}}, seg_mask};

  // Pseudorandom source for the throttle, runs every cycle
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= THROTTLE_SEED | 16'h0001;
    end else if (lfsr == 16'h0000) begin
      lfsr <= THROTTLE_SEED | 16'h0001;
    end else begin
      lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hB400 : 16'h0000);
    end
  end

  // Control register writes
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl_enable   <= 1'b0;
      ctl_throttle <= 9'h000;
      ctl_clear    <= 1'b0;
    end else if (i_csr_write && (i_csr_address == `TPG_CSR_CONTROL)) begin
      ctl_enable   <= i_csr_writedata[`TPG_CTL_ENABLE];
      ctl_throttle <= i_csr_writedata[`TPG_CTL_THR_MSB:`TPG_CTL_THR_LSB];
      ctl_clear    <= i_csr_writedata[`TPG_CTL_CLEAR];
    end
  end

  // Control agent read data, one cycle after the read strobe
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_csr_readdata <= 32'h00000000;
    end else if (i_csr_read) begin
      case (i_csr_address)
        `TPG_CSR_STATUS:  o_csr_readdata <= {PKT_ON ? 1'b1 : 1'b0, SYM7, CHAN8,
                                             SIGNATURE};
        `TPG_CSR_CONTROL: o_csr_readdata <= {14'h0000, ctl_clear, ctl_throttle,
                                             7'h00, ctl_enable};
        `TPG_CSR_FILL:    o_csr_readdata <= {16'h0000, fill_val, 6'h00,
                                             busy};
        default:          o_csr_readdata <= 32'h00000000;
      endcase
    end
  end

  // Command words: high is staged, low pushes the pair
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_low  <= `TPG_CMD_RESET;
      cmd_high <= `TPG_CMD_RESET;
    end else if (i_cmd_write) begin
      if (i_cmd_address == `TPG_CMD_HIGH) begin
        cmd_high <= i_cmd_writedata;
      end else begin
        cmd_low  <= i_cmd_writedata;
      end
    end
  end

  // Command agent read data
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_cmd_readdata <= 32'h00000000;
    end else if (i_cmd_read) begin
      o_cmd_readdata <= (i_cmd_address == `TPG_CMD_HIGH) ? cmd_high : cmd_low;
    end
  end

  // Queue storage; a refused push leaves every entry untouched
  always @(posedge i_clock) begin
    if (push) begin
      q_mem[wr_ptr] <= {cmd_high, i_cmd_writedata};
    end
  end

  // Queue pointers and count, held empty while cleared
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr  <= {QUEUE_AW{1'b0}};
      rd_ptr  <= {QUEUE_AW{1'b0}};
      q_count <= {(QUEUE_AW+1){1'b0}};
    end else if (ctl_clear) begin
      wr_ptr  <= {QUEUE_AW{1'b0}};
      rd_ptr  <= {QUEUE_AW{1'b0}};
      q_count <= {(QUEUE_AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        q_count <= q_count + 1'b1;
      end else if (pop && !push) begin
        q_count <= q_count - 1'b1;
      end
    end
  end

  // Segment sequencer: load one command, run it to its last beat
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state          <= ST_IDLE;
      seg_left       <= 16'h0000;
      seg_chan       <= {CH_W{1'b0}};
      seg_first_flag <= 1'b0;
      seg_last_flag  <= 1'b0;
      seg_first_beat <= 1'b0;
      seg_err        <= 16'h0000;
      seg_mask       <= 8'h00;
      seg_hide_start <= 1'b0;
      seg_hide_end   <= 1'b0;
    end else if (ctl_clear) begin
      state          <= ST_IDLE;
      seg_left       <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pop) begin
            seg_left       <= head[`TPG_LO_SIZE_MSB:`TPG_LO_SIZE_LSB];
            seg_chan       <= chan_wide[CH_W-1:0];
            seg_first_flag <= head[`TPG_LO_FIRST] && PKT_ON;
            seg_last_flag  <= head[`TPG_LO_LAST] && PKT_ON;
            seg_first_beat <= 1'b1;
            seg_err        <= head[32+`TPG_HI_ERR_MSB:32+`TPG_HI_ERR_LSB];
            seg_mask       <= head[32+`TPG_HI_MASK_MSB:32+`TPG_HI_MASK_LSB];
            seg_hide_start <= head[32+`TPG_HI_HIDE_START];
            seg_hide_end   <= head[32+`TPG_HI_HIDE_END];
            if (head[`TPG_LO_SIZE_MSB:`TPG_LO_SIZE_LSB] != 16'h0000) begin
              state <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (beat_go) begin
            seg_first_beat <= 1'b0;
            if (last_beat) begin
              state    <= ST_IDLE;
              seg_left <= 16'h0000;
            end else begin
              seg_left <= seg_left - SPB16;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Per-channel position within the packet, cleared at packet end
  genvar g;
  generate
    for (g = 0; g < NENT; g = g + 1) begin : g_pos
      reg [15:0] pos;
      always @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
          pos <= 16'h0000;
        end else if (ctl_clear) begin
          pos <= 16'h0000;
        end else if (beat_go && (seg_chan == g)) begin
          pos <= pkt_end ? 16'h0000 : pos + n_sym;
        end
      end
      assign pos_flat[g*16 +: 16] = pos;
    end
  endgenerate

  // Symbol lanes: position plus lane index, corrupted by the mask
  wire [DATA_W-1:0] beat_data;
  generate
    for (g = 0; g < SYMBOLS; g = g + 1) begin : g_lane
      localparam [15:0]         LANE     = g;
      wire [15:0]               lane_pos = pos_cur + LANE;
      wire [SYMBOL_BITS+15:0]   lane_ext = {{SYMBOL_BITS{1'b0}}, lane_pos};
      assign beat_data[g*SYMBOL_BITS +: SYMBOL_BITS] =
        lane_ext[SYMBOL_BITS-1:0] ^ mask_ext[SYMBOL_BITS-1:0];
    end
  endgenerate

  // Output stage: a beat stands until the sink takes it or the clear bit drops it
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_valid         <= 1'b0;
      o_data          <= {DATA_W{1'b0}};
      o_channel       <= {CH_W{1'b0}};
      o_startofpacket <= 1'b0;
      o_endofpacket   <= 1'b0;
      o_empty         <= {EMPTY_W{1'b0}};
      o_error         <= {ERR_PW{1'b0}};
    end else if (ctl_clear) begin
      o_valid         <= 1'b0;
    end else if (beat_go) begin
      o_valid         <= 1'b1;
      o_data          <= beat_data;
      o_channel       <= seg_chan;
      o_startofpacket <= seg_first_beat && seg_first_flag && !seg_hide_start;
      o_endofpacket   <= pkt_end && !seg_hide_end;
      o_empty         <= empty_wide[EMPTY_W-1:0];
      o_error         <= (ERROR_WIDTH == 0) ? {ERR_PW{1'b0}} :
                         err_ext[ERR_PW-1:0];
    end else if (i_ready) begin
      o_valid         <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- design/tpg_map.vh ----
// Register offsets, field positions and reset values of the pattern generator
`ifndef TPG_MAP_VH
`define TPG_MAP_VH

// Control and status agent word offsets
`define TPG_CSR_STATUS       2'h0
`define TPG_CSR_CONTROL      2'h1
`define TPG_CSR_FILL         2'h2

// Command agent word offsets
`define TPG_CMD_LOW          1'h0
`define TPG_CMD_HIGH         1'h1

// Status word fields
`define TPG_STAT_SIG_MSB     15
`define TPG_STAT_SIG_LSB     0
`define TPG_STAT_CHAN_MSB    23
`define TPG_STAT_CHAN_LSB    16
`define TPG_STAT_SYM_MSB     30
`define TPG_STAT_SYM_LSB     24
`define TPG_STAT_PKT         31

// Control word fields and reset value
`define TPG_CTL_ENABLE       0
`define TPG_CTL_THR_MSB      16
`define TPG_CTL_THR_LSB      8
`define TPG_CTL_CLEAR        17
`define TPG_CTL_RESET        32'h00000000

// Fill word fields
`define TPG_FILL_BUSY        0
`define TPG_FILL_CNT_MSB     15
`define TPG_FILL_CNT_LSB     7

// Command low word fields
`define TPG_LO_SIZE_MSB      15
`define TPG_LO_SIZE_LSB      0
`define TPG_LO_CHAN_MSB      29
`define TPG_LO_CHAN_LSB      16
`define TPG_LO_FIRST         30
`define TPG_LO_LAST          31

// Command high word fields
`define TPG_HI_ERR_MSB       15
`define TPG_HI_ERR_LSB       0
`define TPG_HI_MASK_MSB      23
`define TPG_HI_MASK_LSB      16
`define TPG_HI_HIDE_START    24
`define TPG_HI_HIDE_END      25
`define TPG_CMD_RESET        32'h00000000

`endif

// ---- verif/tpg_generator_assertions.sv ----
// Port-level checks for the pattern generator
`default_nettype none
module tpg_generator_assertions #(
  parameter          CHANNELS    = 4,
  parameter          CH_W        = 2,
  parameter          SYMBOL_BITS = 8,
  parameter          SYMBOLS     = 4,
  parameter          EMPTY_W     = 2,
  parameter          PACKETS     = 1,
  parameter          ERROR_WIDTH = 8,
  parameter   [15:0] SIGNATURE   = 16'h5A3C, // Arbitrary value
  localparam         ERR_PW      = (ERROR_WIDTH == 0) ? 1 : ERROR_WIDTH
) (
  input wire logic                           i_clock,
  input wire logic                           i_rst_n,
  input wire logic [1:0]                     i_csr_address,
  input wire logic                           i_csr_write,
  input wire logic                           i_csr_read,
  input wire logic [31:0]                    i_csr_writedata,
  input wire logic [31:0]                    o_csr_readdata,
  input wire logic                           i_cmd_address,
  input wire logic                           i_cmd_write,
  input wire logic                           i_cmd_read,
  input wire logic [31:0]                    i_cmd_writedata,
  input wire logic [31:0]                    o_cmd_readdata,
  input wire logic                           o_valid,
  input wire logic                           i_ready,
  input wire logic [SYMBOLS*SYMBOL_BITS-1:0] o_data,
  input wire logic [CH_W-1:0]                o_channel,
  input wire logic                           o_startofpacket,
  input wire logic                           o_endofpacket,
  input wire logic [EMPTY_W-1:0]             o_empty,
  input wire logic [ERR_PW-1:0]              o_error
);
  localparam logic [31:0] STAT = {PACKETS != 0, 7'(SYMBOLS), 8'(CHANNELS), SIGNATURE};
  logic [31:0] ctl_q;
  // Shadow of the control word, reserved bits dropped
  always @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      ctl_q <= 32'h00000000;
    else if (i_csr_write && i_csr_address == 2'h1)
      ctl_q <= i_csr_writedata & 32'h0003FF01;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  status_word_a:
    assert property (i_csr_read && i_csr_address == 2'h0 |=> o_csr_readdata == STAT)
      else $error("Status word wrong");
  ctl_readback_a:
    assert property (i_csr_read && !i_csr_write && i_csr_address == 2'h1
      |=> o_csr_readdata == $past(ctl_q)) else $error("Control readback wrong");
  fill_format_a:
    assert property (i_csr_read && i_csr_address == 2'h2
      |=> o_csr_readdata[31:16] == 16'h0000 && o_csr_readdata[6:1] == 6'h00)
      else $error("Fill reserved bits set");
  busy_flag_a:
    assert property (i_csr_read && i_csr_address == 2'h2 && o_valid |=> o_csr_readdata[0])
      else $error("Busy low with beat pending");
  beat_hold_a:
    assert property (o_valid && !i_ready && !ctl_q[17] |=> o_valid && $stable({o_data, o_channel,
      o_startofpacket, o_endofpacket, o_empty, o_error})) else $error("Beat changed in stall");
  stop_disabled_a:
    assert property (!ctl_q[0] && !o_valid |=> !o_valid) else $error("Beat while disabled");
  stop_throttle_a:
    assert property (ctl_q[16:8] == 9'h000 && !o_valid |=> !o_valid)
      else $error("Beat at zero throttle");
  clear_hold_a:
    assert property (ctl_q[17] |=> !o_valid) else $error("Beat during clear");
  pad_empty_a:
    assert property (o_valid && !o_endofpacket |-> o_empty == '0) else $error("Empty not zero");
  end_beat_c: cover property (o_valid && i_ready && o_endofpacket);
  stall_c: cover property (o_valid && !i_ready);
  push_c: cover property (i_cmd_write && i_cmd_address == 1'b0);
endmodule

bind tpg_generator tpg_generator_assertions #(.CHANNELS(CHANNELS), .CH_W(CH_W),
  .SYMBOL_BITS(SYMBOL_BITS), .SYMBOLS(SYMBOLS), .EMPTY_W(EMPTY_W), .PACKETS(PACKETS),
  .ERROR_WIDTH(ERROR_WIDTH), .SIGNATURE(SIGNATURE)) i_chk (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_csr_address(i_csr_address),
  .i_csr_write(i_csr_write), .i_csr_read(i_csr_read), .i_csr_writedata(i_csr_writedata),
  .o_csr_readdata(o_csr_readdata), .i_cmd_address(i_cmd_address), .i_cmd_write(i_cmd_write),
  .i_cmd_read(i_cmd_read), .i_cmd_writedata(i_cmd_writedata), .o_cmd_readdata(o_cmd_readdata),
  .o_valid(o_valid), .i_ready(i_ready), .o_data(o_data), .o_channel(o_channel),
  .o_startofpacket(o_startofpacket), .o_endofpacket(o_endofpacket), .o_empty(o_empty),
  .o_error(o_error));
`default_nettype wire

// ---- verif/tpg_sink_model.sv ----
// Stream sink that stalls on a fixed pattern and logs accepted beats
`default_nettype none
module tpg_sink_model (
  input  wire logic        i_clock,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_data,
  input  wire logic [1:0]  i_channel,
  input  wire logic        i_sop,
  input  wire logic        i_eop,
  input  wire logic [1:0]  i_empty,
  input  wire logic [7:0]  i_error,
  output logic             o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [45:0] beats[$];
  logic [1:0]  phase = 2'h0;
  // Ready drops one cycle in three so the source must hold its beat
  assign o_ready = (phase != 2'h2);
  always @(negedge i_clock)
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
  // Log each beat on the edge that hands it over
  always @(posedge i_clock)
    if (i_valid && o_ready)
      beats.push_back({i_data, i_channel, i_sop, i_eop, i_empty, i_error});
endmodule
`default_nettype wire

// ---- verif/test_tpg_generator.sv ----
// Self-checking bench for the pattern generator registers and stream
`default_nettype none
module test_tpg_generator;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] SIG = 16'h3C96; // Arbitrary signature value
  logic        i_clock = 1'b0, i_rst_n = 1'b0, cmd_addr = 1'b0, ready;
  logic        csr_wr = 1'b0, csr_rd = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0, valid, sop, eop;
  logic [1:0]  csr_addr = 2'h0, chan, empty;
  logic [7:0]  err;
  logic [31:0] wdata = 32'h00000000, csr_q, cmd_q, rd, data;
  int          i, compares = 0, mismatches = 0, cycles = 0;
  logic [31:0] cmds [8] = '{32'h00000003, 32'hC0010006, 32'h01000000, 32'h7FFE0004,
                            32'h00FF0000, 32'h00030005, 32'h02000000, 32'h80020004};
  logic [45:0] exp_beats [6] = '{{32'h03020100, 6'h18, 8'h03}, {32'h07060504, 6'h16, 8'h03},
    {32'h03020100, 6'h20, 8'h00}, {32'hFCFDFEFF, 6'h30, 8'h00},
    {32'hF8F9FAFB, 6'h30, 8'h00}, {32'h07060504, 6'h20, 8'h00}};
  tpg_generator #(.SIGNATURE(SIG)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_csr_address(csr_addr), .i_csr_write(csr_wr), .i_csr_read(csr_rd),
    .i_csr_writedata(wdata), .o_csr_readdata(csr_q), .i_cmd_address(cmd_addr),
    .i_cmd_write(cmd_wr), .i_cmd_read(cmd_rd), .i_cmd_writedata(wdata),
    .o_cmd_readdata(cmd_q), .o_valid(valid), .i_ready(ready), .o_data(data),
    .o_channel(chan), .o_startofpacket(sop), .o_endofpacket(eop), .o_empty(empty),
    .o_error(err));
  tpg_sink_model i_sink (.i_clock(i_clock), .i_valid(valid), .i_data(data),
    .i_channel(chan), .i_sop(sop), .i_eop(eop), .i_empty(empty), .i_error(err),
    .o_ready(ready));
  // Clock and hang guard
  initial forever #20 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // One register access; strobe stands for one edge, data sampled after it
  task automatic bus(input logic cmd, input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(negedge i_clock);
    csr_addr = a;
    cmd_addr = a[0];
    wdata = d;
    {cmd_wr, cmd_rd, csr_wr, csr_rd} = {cmd && wr, cmd && !wr, !cmd && wr, !cmd && !wr};
    @(negedge i_clock);
    {cmd_wr, cmd_rd, csr_wr, csr_rd} = 4'h0;
    rd = cmd ? cmd_q : csr_q;
  endtask
  task automatic check(input logic [45:0] got, input logic [45:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic cmd, input logic [1:0] a, input logic [31:0] e);
    bus(cmd, 1'b0, a, 32'h00000000);
    check({14'h0000, rd}, {14'h0000, e});
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    rd_chk(1'b0, 2'h0, {1'b1, 7'h04, 8'h04, SIG});
    rd_chk(1'b0, 2'h1, 32'h00000000);
    rd_chk(1'b0, 2'h3, 32'h00000000);
    bus(1'b0, 1'b1, 2'h0, 32'hFFFFFFFF);
    rd_chk(1'b0, 2'h0, {1'b1, 7'h04, 8'h04, SIG});
    bus(1'b0, 1'b1, 2'h1, 32'hFFFD00FE);
    rd_chk(1'b0, 2'h1, 32'h00010000);
    // Overfill the queue while stopped, then a high word alone
    bus(1'b1, 1'b1, 2'h1, 32'h00000000);
    for (i = 0; i < 18; i++) bus(1'b1, 1'b1, 2'h0, 32'hC0010006);
    rd_chk(1'b0, 2'h2, 32'h00000801);
    bus(1'b1, 1'b1, 2'h1, 32'h00AB0000);
    rd_chk(1'b0, 2'h2, 32'h00000801);
    rd_chk(1'b1, 2'h1, 32'h00AB0000);
    check(46'(i_sink.beats.size()), 46'h0);
    // Soft clear empties the queue and refuses pushes until released
    bus(1'b0, 1'b1, 2'h1, 32'h00030000);
    bus(1'b1, 1'b1, 2'h0, 32'hC0010006);
    rd_chk(1'b0, 2'h2, 32'h00000000);
    bus(1'b0, 1'b1, 2'h1, 32'h00010000);
    rd_chk(1'b0, 2'h2, 32'h00000000);
    // Interleaved segments, then zero and mid throttle
    for (i = 0; i < 8; i += 2) begin
      bus(1'b1, 1'b1, 2'h1, cmds[i]);
      bus(1'b1, 1'b1, 2'h0, cmds[i+1]);
    end
    bus(1'b0, 1'b1, 2'h1, 32'h00000001);
    repeat (40) @(negedge i_clock);
    check(46'(i_sink.beats.size()), 46'h0);
    bus(1'b0, 1'b1, 2'h1, 32'h00008001);
    rd = 32'hFFFFFFFF;
    for (i = 0; i < 300 && rd !== 32'h00000000; i++) bus(1'b0, 1'b0, 2'h2, 32'h00000000);
    check({14'h0000, rd}, 46'h0);
    check(46'(i_sink.beats.size()), 46'h6);
    for (i = 0; i < 6; i++)
      check(i < i_sink.beats.size() ? i_sink.beats[i] : 46'h0, exp_beats[i]);
    test_done();
  end
endmodule
`default_nettype wire
